/* File: cmf_pkg.sv */
`default_nettype none
package cmf_pkg;

  // mailbox codes, receive side
  localparam logic [3:0] CODE_RX_INACTIVE  = 4'h0;
  localparam logic [3:0] CODE_RX_EMPTY     = 4'h4;
  localparam logic [3:0] CODE_RX_FULL      = 4'h2;
  localparam logic [3:0] CODE_RX_OVERRUN   = 4'h6;
  localparam logic [3:0] CODE_REMOTE_WAIT  = 4'hA; // remote_answer_wait
  // mailbox codes, transmit side
  localparam logic [3:0] CODE_TX_INACTIVE  = 4'h8;
  localparam logic [3:0] CODE_TX_ABORT     = 4'h9;
  localparam logic [3:0] CODE_TX_SEND      = 4'hC;
  localparam logic [3:0] CODE_TX_ANSWER    = 4'hE; // transmit_answer
  localparam int         CODE_BUSY_BIT     = 0;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL         = 12'h000;
  localparam logic [11:0] OFS_TIMER        = 12'h004;
  localparam logic [11:0] OFS_MB_BASE      = 12'h080;

  // control register field positions
  localparam int CTRL_REMOTE_STORE_BIT     = 0;  // remote_request_store
  localparam int CTRL_BUSY_REPORT_BIT      = 1;  // tx_busy_report_enable

  // descriptor word zero field positions
  localparam int W0_FDF_BIT                = 31;
  localparam int W0_CODE_LSB               = 24;
  localparam int W0_RTR_BIT                = 20;
  localparam int W0_DLC_LSB                = 16;
  localparam int W0_STAMP_LSB              = 0;

  // values after reset
  localparam logic [15:0] TIMER_RST        = 16'h0000;
  localparam logic [3:0]  CODE_RST         = 4'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  // frame attributes handed over by the frame engine on a move-in
  typedef struct packed {
    logic       fd_format_flag;
    logic       rtr;
    logic [3:0] dlc;
  } cmf_frame_t;

  // one mailbox as held by this block
  typedef struct packed {
    logic       fd_format_flag;
    logic [3:0] code;
    logic       rtr;
    logic [3:0] dlc;
    logic [15:0] stamp;
    logic       serviced;
  } cmf_mb_t;

  // payload size in bytes for a length code
  function automatic logic [6:0] cmf_payload_bytes(input logic [3:0] dlc);
    logic [6:0] n;
    n = 7'h00;
    unique case (dlc)
      4'h9:    n = 7'h0C;
      4'hA:    n = 7'h10;
      4'hB:    n = 7'h14;
      4'hC:    n = 7'h18;
      4'hD:    n = 7'h20;
      4'hE:    n = 7'h30;
      4'hF:    n = 7'h40;
      default: n = {3'h0, dlc};
    endcase
    return n;
  endfunction

  // byte-lane merge for a partial bus write
  function automatic logic [31:0] cmf_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

/* File: cmf_mailbox_code.sv */
`timescale 1ns/100ps
`default_nettype none
module cmf_mailbox_code
  import cmf_pkg::*;
#(
  parameter int MB_NUM = 32,                         // number of mailboxes
  parameter int IW     = $clog2(MB_NUM)              // mailbox index width
)(
  input  wire logic              CLK,                // 125 MHz module clock
  input  wire logic              NRST,               // async reset, active low
  input  wire logic [11:0]       AWADDR,             // write address
  input  wire logic              AWVALID,            // write address valid
  output logic                   AWREADY,            // write address ready
  input  wire logic [31:0]       WDATA,              // write data
  input  wire logic [3:0]        WSTRB,              // write byte lanes
  input  wire logic              WVALID,             // write data valid
  output logic                   WREADY,             // write data ready
  output logic [1:0]             BRESP,              // write answer
  output logic                   BVALID,             // write answer valid
  input  wire logic              BREADY,             // write answer ready
  input  wire logic [11:0]       ARADDR,             // read address
  input  wire logic              ARVALID,            // read address valid
  output logic                   ARREADY,            // read address ready
  output logic [31:0]            RDATA,              // read data
  output logic [1:0]             RRESP,              // read answer
  output logic                   RVALID,             // read data valid
  input  wire logic              RREADY,             // read data ready
  input  wire logic              ID_START,           // identifier begins on bus
  input  wire logic [IW-1:0]     ID_MB,              // mailbox of that frame
  input  wire logic              MOVE_START,         // move-in begins
  input  wire logic              MOVE_DONE,          // move-in complete
  input  wire logic [IW-1:0]     MOVE_MB,            // move-in target
  input  wire cmf_frame_t        MOVE_FRAME,         // received frame attributes
  input  wire logic              REMOTE_HIT,         // remote request matched
  input  wire logic [IW-1:0]     REMOTE_MB,          // mailbox it matched
  input  wire logic              TX_DONE,            // frame sent successfully
  input  wire logic [IW-1:0]     TX_MB,              // mailbox it came from
  input  wire logic [IW-1:0]     TX_SEL,             // mailbox the engine inspects
  output logic [MB_NUM-1:0]      RX_ELIGIBLE,        // may take part in matching
  output logic [MB_NUM-1:0]      TX_ELIGIBLE,        // may take part in arbitration
  output logic [MB_NUM-1:0]      TX_REMOTE_FRAME,    // sends a remote frame
  output logic [6:0]             TX_PAYLOAD_BYTES    // data bytes of TX_SEL
);

  // all state in one packed struct:
  // mailbox table, timer, control bits,
  // bus slave registers and the maps;
  // the table sits in flops, not ram, so
  // matching can see every mailbox in
  // the same cycle
  typedef struct packed {
    cmf_mb_t [MB_NUM-1:0] mb;
    logic [15:0]          timer;
    logic                 remote_request_store;
    logic                 tx_busy_report_enable;
    logic                 lock_v;
    logic [IW-1:0]        lock_idx;
    logic                 awready;
    logic                 wready;
    logic [11:0]          awaddr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic [1:0]           bresp;
    logic                 bvalid;
    logic                 arready;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 rvalid;
    logic [MB_NUM-1:0]    rx_elig;
    logic [MB_NUM-1:0]    tx_elig;
    logic [MB_NUM-1:0]    tx_rem;
    logic [6:0]           pay;
  } cmf_state_t;

  // after reset every channel is ready and
  // every mailbox is rx inactive, so none
  // matches or arbitrates before software
  localparam cmf_state_t ST_RST = '{timer: TIMER_RST, awready: 1'b1, wready: 1'b1,
                                     arready: 1'b1, default: '0};

  cmf_state_t        s_q;
  cmf_state_t        s_d;
  logic [MB_NUM-1:0] rx_elig_w;
  logic [MB_NUM-1:0] tx_elig_w;
  logic [MB_NUM-1:0] tx_rem_w;

  // the mailbox window starts at a fixed base;
  // addresses past the last mailbox get an
  // error answer instead of aliasing
  // mailbox word index of an address, and whether it lands on a mailbox
  function automatic logic mb_hit(input logic [11:0] a);
    logic [9:0] w;
    w = a[11:2] - OFS_MB_BASE[11:2];
    return (a[11:2] >= OFS_MB_BASE[11:2]) && (int'(w) < MB_NUM);
  endfunction

  // index of the mailbox behind an address
  function automatic logic [IW-1:0] mb_idx(input logic [11:0] a);
    logic [9:0] w;
    w = a[11:2] - OFS_MB_BASE[11:2];
    return w[IW-1:0];
  endfunction

  // reserved bits read as zero; the stamp
  // is read-only, a write to it is dropped
  // descriptor word zero as software sees it
  function automatic logic [31:0] word0(input cmf_mb_t m);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[W0_FDF_BIT]                  = m.fd_format_flag;
    r[W0_CODE_LSB +: 4]            = m.code;
    r[W0_RTR_BIT]                  = m.rtr;
    r[W0_DLC_LSB +: 4]             = m.dlc;
    r[W0_STAMP_LSB +: 16]          = m.stamp;
    return r;
  endfunction

  // the maps are registered, so the engine
  // sees a code change two clocks after
  // the event and must tolerate that lag
  // per-mailbox participation, looked at by the frame engine
  for (genvar i = 0; i < MB_NUM; i++)
  begin : g_elig
    logic [3:0] c;
    assign c = s_q.mb[i].code;
    // busy, inactive and tx codes stay out; remote wait only while store is off
    assign rx_elig_w[i] = !c[CODE_BUSY_BIT]
                          && (c != CODE_RX_INACTIVE)
                          && ((c == CODE_RX_EMPTY) || (c == CODE_RX_FULL) || (c == CODE_RX_OVERRUN)
                              || ((c == CODE_REMOTE_WAIT) && !s_q.remote_request_store));
    // rx and tx codes never overlap, so a
    // mailbox sits in one map at most
    // only send and answer codes arbitrate; inactive, abort and remote wait do not
    assign tx_elig_w[i] = (c == CODE_TX_SEND) || (c == CODE_TX_ANSWER);
    assign tx_rem_w[i]  = s_q.mb[i].rtr;
  end

  // next state: bus slave, control bits, then the frame engine events
  always_comb
  begin
    logic [31:0] nw;
    logic [3:0]  base;
    nw   = 32'h0000_0000;
    base = 4'h0;
    s_d  = s_q;
    // the timer wraps at 16 bits, so stamps
    // only give differences modulo 65536
    s_d.timer = s_q.timer + 16'h0001;

    // each channel is held until its answer
    // is taken: one write in flight at most
    // write address and data are taken in either order
    if (AWVALID && s_q.awready)
    begin
      s_d.awaddr  = AWADDR;
      s_d.awready = 1'b0;
    end
    if (WVALID && s_q.wready)
    begin
      s_d.wdata  = WDATA;
      s_d.wstrb  = WSTRB;
      s_d.wready = 1'b0;
    end
    // unmapped writes get an error; timer
    // writes are taken and dropped, since
    // the counter runs free
    // both held and no answer outstanding: perform the write
    if (!s_q.awready && !s_q.wready && !s_q.bvalid)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_OKAY;
      if (s_q.awaddr == OFS_CTRL)
      begin
        // only two control bits exist; the
        // rest of the word is dropped
        nw = cmf_merge({30'h0, s_q.tx_busy_report_enable, s_q.remote_request_store},
                       s_q.wdata, s_q.wstrb);
        s_d.remote_request_store  = nw[CTRL_REMOTE_STORE_BIT];
        s_d.tx_busy_report_enable = nw[CTRL_BUSY_REPORT_BIT];
      end
      else if (mb_hit(s_q.awaddr))
      begin
        // a code written here acts exactly like one set by the hardware
        // a cpu write also clears serviced, so
        // a fresh setup starts as not serviced
        nw = cmf_merge(word0(s_q.mb[mb_idx(s_q.awaddr)]), s_q.wdata, s_q.wstrb);
        s_d.mb[mb_idx(s_q.awaddr)].fd_format_flag = nw[W0_FDF_BIT];
        s_d.mb[mb_idx(s_q.awaddr)].code           = nw[W0_CODE_LSB +: 4];
        s_d.mb[mb_idx(s_q.awaddr)].rtr            = nw[W0_RTR_BIT];
        s_d.mb[mb_idx(s_q.awaddr)].dlc            = nw[W0_DLC_LSB +: 4];
        s_d.mb[mb_idx(s_q.awaddr)].serviced       = 1'b0;
      end
      else if (s_q.awaddr != OFS_TIMER)
      begin
        s_d.bresp = RESP_SLVERR;
      end
    end
    if (s_q.bvalid && BREADY)
    begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // a read never waits: rdata is built at
    // the address handshake from old state
    // read: data latched at the address handshake, answered next cycle
    if (ARVALID && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = RESP_OKAY;
      s_d.rdata   = 32'h0000_0000;
      if (ARADDR == OFS_CTRL)
      begin
        s_d.rdata[CTRL_REMOTE_STORE_BIT] = s_q.remote_request_store;
        s_d.rdata[CTRL_BUSY_REPORT_BIT]  = s_q.tx_busy_report_enable;
      end
      else if (ARADDR == OFS_TIMER)
      begin
        // timer read releases the lock and marks the held mailbox serviced
        // software uses this read as the
        // unlock step after a mailbox read
        s_d.rdata[15:0] = s_q.timer;
        if (s_q.lock_v)
        begin
          s_d.mb[s_q.lock_idx].serviced = 1'b1;
        end
        s_d.lock_v = 1'b0;
      end
      else if (mb_hit(ARADDR))
      begin
        // reading another mailbox also releases the previous one
        // re-reading the same mailbox keeps
        // it locked and does not service it
        s_d.rdata = word0(s_q.mb[mb_idx(ARADDR)]);
        if (s_q.lock_v && (s_q.lock_idx != mb_idx(ARADDR)))
        begin
          s_d.mb[s_q.lock_idx].serviced = 1'b1;
        end
        s_d.lock_v   = 1'b1;
        s_d.lock_idx = mb_idx(ARADDR);
      end
      else
      begin
        s_d.rresp = RESP_SLVERR;
      end
    end
    if (s_q.rvalid && RREADY)
    begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // a cpu write and a hardware update in
    // one cycle leave the hardware result,
    // which the cpu sees on its next read;
    // the engine cannot be stalled
    // frame engine events come after the bus so that they win a collision
    // stamp taken as the identifier starts,
    // for tx and rx frames alike
    if (ID_START)
    begin
      s_d.mb[ID_MB].stamp = s_q.timer;
    end
    // the busy bit keeps the mailbox out of
    // matching while its contents change
    if (MOVE_START)
    begin
      s_d.mb[MOVE_MB].code[CODE_BUSY_BIT] = 1'b1;
    end
    if (MOVE_DONE)
    begin
      // the pre-move code, with the busy bit stripped, decides the outcome
      // serviced picks full or overrun; it is
      // cleared again for the new frame
      base = s_d.mb[MOVE_MB].code & 4'hE;
      unique case (base)
        CODE_RX_EMPTY:
          s_d.mb[MOVE_MB].code = CODE_RX_FULL;
        CODE_RX_FULL, CODE_RX_OVERRUN:
          s_d.mb[MOVE_MB].code = s_d.mb[MOVE_MB].serviced ? CODE_RX_FULL
                                                          : CODE_RX_OVERRUN;
        default:
          s_d.mb[MOVE_MB].code = base;
      endcase
      s_d.mb[MOVE_MB].fd_format_flag = MOVE_FRAME.fd_format_flag;
      s_d.mb[MOVE_MB].rtr            = MOVE_FRAME.rtr;
      s_d.mb[MOVE_MB].dlc            = MOVE_FRAME.dlc;
      s_d.mb[MOVE_MB].serviced       = 1'b0;
    end
    // remote request into a waiting answer mailbox arms the response
    // with the store bit set this code
    // neither matches nor arbitrates
    if (REMOTE_HIT && !s_q.remote_request_store && (s_d.mb[REMOTE_MB].code == CODE_REMOTE_WAIT))
    begin
      s_d.mb[REMOTE_MB].code = CODE_TX_ANSWER;
    end
    // a done for a mailbox that is not
    // sending is ignored, so aborts stay
    if (TX_DONE)
    begin
      unique case (s_d.mb[TX_MB].code)
        CODE_TX_SEND:
          s_d.mb[TX_MB].code = s_d.mb[TX_MB].rtr ? CODE_RX_EMPTY
                                                 : CODE_TX_INACTIVE;
        CODE_TX_ANSWER:
          s_d.mb[TX_MB].code = CODE_REMOTE_WAIT;
        default:
          s_d.mb[TX_MB].code = s_d.mb[TX_MB].code;
      endcase
    end

    // participation maps and the inspected mailbox's payload, all registered
    // payload is zero for a remote frame,
    // whatever the length code says
    s_d.rx_elig = rx_elig_w;
    s_d.tx_elig = tx_elig_w;
    s_d.tx_rem  = tx_rem_w;
    s_d.pay     = s_q.mb[TX_SEL].rtr ? 7'h00
                                     : cmf_payload_bytes(s_q.mb[TX_SEL].dlc);
  end

  // async reset loads constants only; the
  // wide struct is one register on purpose
  // single state register
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s_q <= ST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // no logic between flops and pins, so
  // output timing is one clock-to-out
  // every output is a field of the state register
  assign AWREADY          = s_q.awready;
  assign WREADY           = s_q.wready;
  assign BRESP            = s_q.bresp;
  assign BVALID           = s_q.bvalid;
  assign ARREADY          = s_q.arready;
  assign RDATA            = s_q.rdata;
  assign RRESP            = s_q.rresp;
  assign RVALID           = s_q.rvalid;
  assign RX_ELIGIBLE      = s_q.rx_elig;
  assign TX_ELIGIBLE      = s_q.tx_elig;
  assign TX_REMOTE_FRAME  = s_q.tx_rem;
  assign TX_PAYLOAD_BYTES = s_q.pay;

endmodule // cmf_mailbox_code
`default_nettype wire

/* File: cmf_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cmf_engine_model
  import cmf_pkg::*;
#(
  parameter int IW = 5              // index width
)(
  input  wire logic     CLK,        // clock
  output logic          ID_START,   // id begins
  output logic [IW-1:0] ID_MB,      // its mailbox
  output logic          MOVE_START, // move begins
  output logic          MOVE_DONE,  // move ends
  output logic [IW-1:0] MOVE_MB,    // move target
  output var cmf_frame_t MOVE_FRAME, // frame fields
  output logic          REMOTE_HIT, // remote match
  output logic [IW-1:0] REMOTE_MB,  // its mailbox
  output logic          TX_DONE,    // frame sent
  output logic [IW-1:0] TX_MB       // its mailbox
);
  // quiet bus at time zero
  initial
  begin
    {ID_START, MOVE_START, MOVE_DONE, REMOTE_HIT, TX_DONE} = 5'h00;
    {ID_MB, MOVE_MB, REMOTE_MB, TX_MB} = 20'h00000;
    MOVE_FRAME = 6'h00;
  end
  // one-clock strobe: 0 id start, 1 remote hit, else sent
  task automatic pulse(input int k, input logic [IW-1:0] mb);
    @(posedge CLK);
    case (k)
      0: ID_START <= 1'b1;
      1: REMOTE_HIT <= 1'b1;
      default: TX_DONE <= 1'b1;
    endcase
    {ID_MB, REMOTE_MB, TX_MB} <= {3{mb}};
    @(posedge CLK);
    {ID_START, REMOTE_HIT, TX_DONE} <= 3'h0;
    // stale index would hide a late sample, so flip it
    {ID_MB, REMOTE_MB, TX_MB} <= {3{~mb}};
  endtask
  // move-in: start, then done with the frame a clock later
  task automatic move(input logic [IW-1:0] mb, input cmf_frame_t f);
    @(posedge CLK);
    MOVE_START <= 1'b1;
    MOVE_MB <= mb;
    @(posedge CLK);
    MOVE_START <= 1'b0;
    MOVE_DONE <= 1'b1;
    MOVE_FRAME <= f;
    @(posedge CLK);
    MOVE_DONE <= 1'b0;
    MOVE_MB <= ~mb;
    MOVE_FRAME <= cmf_frame_t'(~f);
  endtask
endmodule // cmf_engine_model
`default_nettype wire

/* File: cmf_mailbox_code_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module cmf_mailbox_code_sva
  import cmf_pkg::*;
#(
  parameter int MB_NUM = 32,                // mailboxes
  parameter int IW     = 5                  // index width
)(
  input wire logic              CLK,              // clock
  input wire logic              NRST,             // reset
  input wire logic              AWVALID,          // aw valid
  input wire logic              AWREADY,          // aw ready
  input wire logic              WVALID,           // w valid
  input wire logic              WREADY,           // w ready
  input wire logic              BVALID,           // b valid
  input wire logic              BREADY,           // b ready
  input wire logic              ARVALID,          // ar valid
  input wire logic              ARREADY,          // ar ready
  input wire logic              RVALID,           // r valid
  input wire logic              RREADY,           // r ready
  input wire logic              MOVE_START,       // move begins
  input wire logic [IW-1:0]     MOVE_MB,          // move target
  input wire logic              TX_DONE,          // frame sent
  input wire logic [IW-1:0]     TX_MB,            // its mailbox
  input wire logic [IW-1:0]     TX_SEL,           // inspected
  input wire logic [MB_NUM-1:0] RX_ELIGIBLE,      // match map
  input wire logic [MB_NUM-1:0] TX_ELIGIBLE,      // arbitration map
  input wire logic [MB_NUM-1:0] TX_REMOTE_FRAME,  // remote map
  input wire logic [6:0]        TX_PAYLOAD_BYTES  // payload size
);
  // single domain, clock and reset stated once
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !WREADY ##1 BVALID)
    else $error("late write answer");
  a_write_release: assert property (BVALID && BREADY |=> !BVALID && AWREADY && WREADY)
    else $error("write answer kept");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("late read answer");
  a_read_release: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read answer kept");
  a_payload_legal:
    assert property (TX_PAYLOAD_BYTES inside {[7'h00:7'h08], 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40})
    else $error("illegal payload size");
  a_remote_nodata:
    assert property (($stable(TX_SEL) && TX_REMOTE_FRAME[TX_SEL]) [*3] |-> TX_PAYLOAD_BYTES == 7'h00)
    else $error("remote frame with data");
  a_move_busy: assert property (MOVE_START |-> ##2 !RX_ELIGIBLE[$past(MOVE_MB, 2)])
    else $error("busy mailbox matches");
  a_tx_leave: assert property (TX_DONE |-> ##2 !TX_ELIGIBLE[$past(TX_MB, 2)])
    else $error("sent mailbox still arbitrates");
  a_maps_apart: assert property ((RX_ELIGIBLE & TX_ELIGIBLE) == '0)
    else $error("mailbox in both maps");
endmodule // cmf_mailbox_code_sva

bind cmf_mailbox_code cmf_mailbox_code_sva #(.MB_NUM(MB_NUM), .IW(IW)) u_sva (.CLK, .NRST, .AWVALID, .AWREADY,
  .WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .MOVE_START, .MOVE_MB, .TX_DONE,
  .TX_MB, .TX_SEL, .RX_ELIGIBLE, .TX_ELIGIBLE, .TX_REMOTE_FRAME, .TX_PAYLOAD_BYTES);
`default_nettype wire

/* File: cmf_mailbox_code_test.sv */
`timescale 1ns/100ps
`default_nettype none
module cmf_mailbox_code_test;
  import cmf_pkg::*;
  logic        CLK, NRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID;
  logic        RREADY, ID_START, MOVE_START, MOVE_DONE, REMOTE_HIT, TX_DONE;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, RX_ELIGIBLE, TX_ELIGIBLE, TX_REMOTE_FRAME, rd_d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rd_r;
  logic [4:0]  ID_MB, MOVE_MB, REMOTE_MB, TX_MB, TX_SEL;
  logic [6:0]  TX_PAYLOAD_BYTES;
  cmf_frame_t  MOVE_FRAME;
  int          mismatches;
  int          checks_done;

  cmf_mailbox_code #(.MB_NUM(32)) dut (.CLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .ID_START, .ID_MB,
    .MOVE_START, .MOVE_DONE, .MOVE_MB, .MOVE_FRAME, .REMOTE_HIT, .REMOTE_MB, .TX_DONE, .TX_MB, .TX_SEL,
    .RX_ELIGIBLE, .TX_ELIGIBLE, .TX_REMOTE_FRAME, .TX_PAYLOAD_BYTES);
  cmf_engine_model #(.IW(5)) eng (.CLK, .ID_START, .ID_MB, .MOVE_START, .MOVE_DONE, .MOVE_MB, .MOVE_FRAME,
    .REMOTE_HIT, .REMOTE_MB, .TX_DONE, .TX_MB);

  // 125 MHz clock
  initial
  begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one bus access, write or read; each channel dropped once taken
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    ARADDR <= a;
    WDATA <= d;
    {AWVALID, WVALID, BREADY} <= {3{w}};
    {ARVALID, RREADY} <= {2{!w}};
    forever
    begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (ARREADY) ARVALID <= 1'b0;
      if (BVALID || RVALID)
      begin
        rd_d = RDATA;
        rd_r = w ? BRESP : RRESP;
        {BREADY, RREADY} <= 2'h0;
        break;
      end
    end
  endtask
  function automatic logic [11:0] ma(input int i);
    return OFS_MB_BASE + 12'(4 * i);
  endfunction
  // classical format only, so an answer code stays legal
  task automatic setmb(input int i, input logic [3:0] code, input logic rtr, input logic [3:0] dlc);
    bus(1'b1, ma(i), {8'h00 | code, 3'h0, rtr, dlc, 16'h0000});
  endtask
  task automatic code_is(input int i, input logic [3:0] exp);
    bus(1'b0, ma(i), 32'h00000000);
    chk("code", 32'(rd_d[27:24]), 32'(exp));
    chk("resp", 32'(rd_r), 32'(RESP_OKAY));
  endtask
  // maps are registered from state, so let them settle first
  task automatic maps(input logic [31:0] rx, input logic [31:0] tx);
    repeat (3) @(posedge CLK);
    #1;
    chk("rx map", RX_ELIGIBLE, rx);
    chk("tx map", TX_ELIGIBLE, tx);
  endtask
  task automatic s_reset;
    code_is(7, CODE_RST);
    maps(32'h00000000, 32'h00000000);
    bus(1'b0, 12'hFFC, 32'h00000000);
    chk("unmapped", 32'(rd_r), 32'(RESP_SLVERR));
    bus(1'b1, 12'hFFC, 32'h00000000);
    chk("unmapped wr", 32'(rd_r), 32'(RESP_SLVERR));
  endtask
  // id starts five clocks apart stamp five apart
  task automatic s_stamp;
    logic [15:0] s1;
    eng.pulse(0, 5'h01);
    repeat (3) @(posedge CLK);
    eng.pulse(0, 5'h02);
    bus(1'b0, ma(1), 32'h00000000);
    s1 = rd_d[15:0];
    bus(1'b0, ma(2), 32'h00000000);
    chk("stamp gap", 32'(16'(rd_d[15:0] - s1)), 32'h00000005);
  endtask
  // reads alone lock; a timer or other mailbox read services
  task automatic s_rx;
    setmb(1, CODE_RX_EMPTY, 1'b0, 4'h0);
    maps(32'h00000002, 32'h00000000);
    eng.move(1, 6'h0F);
    code_is(1, CODE_RX_FULL);
    chk("length", 32'(rd_d[19:16]), 32'h0000000F);
    eng.move(1, 6'h01);
    code_is(1, CODE_RX_OVERRUN);
    eng.move(1, 6'h01);
    code_is(1, CODE_RX_OVERRUN);
    bus(1'b0, OFS_TIMER, 32'h00000000);
    eng.move(1, 6'h01);
    code_is(1, CODE_RX_FULL);
    bus(1'b0, ma(2), 32'h00000000);
    eng.move(1, 6'h02);
    code_is(1, CODE_RX_FULL);
  endtask
  // busy reporting on; the bit is only stored, so tx codes read whole either way
  task automatic s_tx_data;
    int t[7] = '{12, 16, 20, 24, 32, 48, 64};
    bus(1'b1, OFS_CTRL, 32'h00000002);
    setmb(3, CODE_TX_INACTIVE, 1'b0, 4'h0);
    maps(32'h00000002, 32'h00000000);
    setmb(3, CODE_TX_ABORT, 1'b0, 4'h0);
    maps(32'h00000002, 32'h00000000);
    for (int d = 0; d < 16; d++)
    begin
      setmb(3, CODE_TX_SEND, 1'b0, 4'(d));
      maps(32'h00000002, 32'h00000008);
      chk("bytes", 32'(TX_PAYLOAD_BYTES), 32'((d < 9) ? d : t[d - 9]));
    end
    eng.pulse(2, 5'h03);
    code_is(3, CODE_TX_INACTIVE);
    setmb(3, CODE_TX_SEND, 1'b1, 4'hF);
    maps(32'h00000002, 32'h00000008);
    chk("remote", 32'(TX_REMOTE_FRAME[3]), 32'h00000001);
    chk("bytes", 32'(TX_PAYLOAD_BYTES), 32'h00000000);
    eng.pulse(2, 5'h03);
    code_is(3, CODE_RX_EMPTY);
    maps(32'h0000000A, 32'h00000000);
  endtask
  task automatic s_answer;
    setmb(4, CODE_REMOTE_WAIT, 1'b1, 4'h0);
    maps(32'h0000001A, 32'h00000000);
    eng.pulse(1, 5'h04);
    code_is(4, CODE_TX_ANSWER);
    maps(32'h0000000A, 32'h00000010);
    chk("remote", 32'(TX_REMOTE_FRAME[4]), 32'h00000001);
    eng.pulse(2, 5'h04);
    code_is(4, CODE_REMOTE_WAIT);
    setmb(4, CODE_TX_ANSWER, 1'b0, 4'h0);
    maps(32'h0000000A, 32'h00000010);
    chk("remote", 32'(TX_REMOTE_FRAME[4]), 32'h00000000);
    eng.pulse(2, 5'h04);
    code_is(4, CODE_REMOTE_WAIT);
    bus(1'b1, OFS_CTRL, 32'h00000003);
    bus(1'b0, OFS_CTRL, 32'h00000000);
    chk("control", rd_d, 32'h00000003);
    maps(32'h0000000A, 32'h00000000);
    eng.pulse(1, 5'h04);
    code_is(4, CODE_REMOTE_WAIT);
  endtask
  // reset for 20 clocks, then the scenarios
  initial
  begin
    {NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
    {AWADDR, ARADDR, WDATA} = 56'h00000000000000;
    WSTRB = 4'hF;
    TX_SEL = 5'h03;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    s_reset;
    s_stamp;
    s_rx;
    s_tx_data;
    s_answer;
    tally_and_finish;
  end
  // run needs about 300 clocks; a hang ends here
  initial
  begin
    repeat (20000) @(posedge CLK);
    mismatches++;
    tally_and_finish;
  end
endmodule // cmf_mailbox_code_test
`default_nettype wire
